// >>> iohch_regs.vh
// Constants for the io and homing command handler: offsets, fields, codes, reset values
`ifndef IOHCH_REGS_VH
`define IOHCH_REGS_VH

// ************************************************************
// Register byte offsets on the Avalon-MM slave
// ************************************************************
`define IOHCH_OFS_CTRL 5'h00
`define IOHCH_OFS_ACC 5'h04
`define IOHCH_OFS_STAT 5'h08
`define IOHCH_OFS_CNT 5'h0c

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define IOHCH_CTRL_STANDALONE 0
`define IOHCH_CTRL_MOD_LSB 8
`define IOHCH_CTRL_HOST_LSB 16
`define IOHCH_RST_MOD_ADDR 8'h01
`define IOHCH_RST_HOST_ADDR 8'h02
`define IOHCH_RST_ACC 32'h00000000
`define IOHCH_RST_GPOUT 8'h00
`define IOHCH_RST_PULLUP 1'b1

// ************************************************************
// Status register fields
// ************************************************************
`define IOHCH_STAT_GP_LSB 0
`define IOHCH_STAT_PULLUP 8
`define IOHCH_STAT_BUSY 9
`define IOHCH_STAT_LAST_LSB 16

// ************************************************************
// Frame layout and command codes
// ************************************************************
`define IOHCH_FRAME_LAST 4'h8
`define IOHCH_CMD_HOME 8'h0d
`define IOHCH_CMD_SET 8'h0e
`define IOHCH_CMD_GET 8'h0f
`define IOHCH_HOME_START 8'h00
`define IOHCH_HOME_STOP 8'h01
`define IOHCH_HOME_QUERY 8'h02
`define IOHCH_BANK_DIN 8'h00
`define IOHCH_BANK_ANA 8'h01
`define IOHCH_BANK_OUT 8'h02
`define IOHCH_PORT_ALL 8'hff
`define IOHCH_PORT_ADC0 8'h00
`define IOHCH_PORT_ADC4 8'h04
`define IOHCH_PORT_SUPPLY 8'h08
`define IOHCH_PORT_TEMP0 8'h09
`define IOHCH_PORT_TEMP1 8'h0a
`define IOHCH_PORT_TEMP2 8'h0b
`define IOHCH_VAL_FROM_ACC 32'hffffffff

// ************************************************************
// Reply status codes
// ************************************************************
`define IOHCH_ST_OK 8'h64
`define IOHCH_ST_BAD_CMD 8'h02
`define IOHCH_ST_BAD_TYPE 8'h03
`define IOHCH_ST_BAD_VALUE 8'h04

`endif

// >>> iohch_reply_tx.v
// Reply frame sender: nine bytes with running modulo-256 checksum
`timescale 1ns/1ns
`include "iohch_regs.vh"

module iohch_reply_tx (
    input wire i_clk_sys, // System clock
    input wire i_rst_b, // Async reset, active low
    input wire i_start, // Load a reply and begin sending
    input wire [7:0] i_host_addr, // Host address byte
    input wire [7:0] i_mod_addr, // Own module address byte
    input wire [7:0] i_status, // Status byte
    input wire [7:0] i_instr, // Echoed instruction
    input wire [31:0] i_value, // Value, sent high byte first
    output reg [7:0] o_tx_data, // Byte on offer
    output reg o_tx_valid, // Byte on offer is valid
    input wire i_tx_ready // Sink takes the byte
);

    reg [7:0] fld [0:7];
    reg [3:0] idx;
    reg [7:0] sum;
    wire [7:0] cur_byte;
    integer k;

    assign cur_byte = fld[idx[2:0]];

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tx_data <= 8'h00;
            o_tx_valid <= 1'b0;
            idx <= 4'h0;
            sum <= 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                fld[k] <= 8'h00;
            end
        end else if (i_start && !o_tx_valid) begin
            fld[0] <= i_host_addr;
            fld[1] <= i_mod_addr;
            fld[2] <= i_status;
            fld[3] <= i_instr;
            fld[4] <= i_value[31:24];
            fld[5] <= i_value[23:16];
            fld[6] <= i_value[15:8];
            fld[7] <= i_value[7:0];
            o_tx_data <= i_host_addr;
            o_tx_valid <= 1'b1;
            sum <= i_host_addr;
            idx <= 4'h1;
        end else if (o_tx_valid && i_tx_ready) begin
            if (idx == 4'h9) begin
                o_tx_valid <= 1'b0;
                idx <= 4'h0;
            end else if (idx == `IOHCH_FRAME_LAST) begin
                o_tx_data <= sum;
                idx <= idx + 4'h1;
            end else begin
                o_tx_data <= cur_byte;
                sum <= sum + cur_byte;
                idx <= idx + 4'h1;
            end
        end
    end

endmodule

// >>> iohch_top.v
// Command handler for homing, general outputs, pull-ups and input reads
`timescale 1ns/1ns
`include "iohch_regs.vh"

module iohch_top #(
    parameter N_AXIS = 3 // Number of homing axes
) (
    input wire i_clk_sys, // System clock, 10 MHz
    input wire i_rst_b, // Async reset, active low
    input wire [4:0] i_avs_address, // Avalon byte address
    input wire i_avs_read, // Avalon read request
    input wire i_avs_write, // Avalon write request
    input wire [3:0] i_avs_byteenable, // Avalon write byte lanes
    input wire [31:0] i_avs_writedata, // Avalon write data
    output reg [31:0] o_avs_readdata, // Avalon read data
    output wire o_avs_waitrequest, // Avalon stall
    input wire [7:0] i_rx_data, // Command byte from host link
    input wire i_rx_valid, // Command byte valid
    output wire o_rx_ready, // Handler accepts a command byte
    output wire [7:0] o_tx_data, // Reply byte to host link
    output wire o_tx_valid, // Reply byte valid
    input wire i_tx_ready, // Host link takes reply byte
    output reg [N_AXIS-1:0] o_home_start, // One-cycle homing start per axis
    output reg [N_AXIS-1:0] o_home_stop, // One-cycle homing stop per axis
    input wire [N_AXIS-1:0] i_home_busy, // Homing search active per axis
    output reg [7:0] o_gp_out, // General outputs, bit n is port n
    output reg o_stop_pullup_en, // Pull-ups on all left and right stop inputs
    input wire [7:0] i_din, // Digital input states, bit n is port n
    input wire [11:0] i_adc_zero, // ADC result of analog capable input zero
    input wire [11:0] i_adc_four, // ADC result of analog capable input four
    input wire [15:0] i_supply_dv, // Supply voltage in tenths of a volt
    input wire [15:0] i_temp_a, // Temperature a in degrees Celsius, signed
    input wire [15:0] i_temp_b, // Temperature b in degrees Celsius, signed
    input wire [15:0] i_temp_c // Temperature c in degrees Celsius, signed
);

    // ************************************************************
    // States
    // ************************************************************
    localparam S_RX = 3'b001;
    localparam S_EXEC = 3'b010;
    localparam S_SEND = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [7:0] fb [0:7];
    reg [3:0] rx_cnt;
    reg [7:0] rx_sum;
    reg [31:0] acc;
    reg standalone;
    reg [7:0] mod_addr;
    reg [7:0] host_addr;
    reg [7:0] last_status;
    reg [15:0] exec_cnt;
    reg [15:0] drop_cnt;
    reg bus_ack;

    wire [7:0] f_instr;
    wire [7:0] f_type;
    wire [7:0] f_bank;
    wire [31:0] f_value;
    wire [N_AXIS-1:0] busy_shift;
    wire rx_take;
    wire frame_ok;
    wire tx_start;
    wire bus_req;
    wire bus_wr;

    assign f_instr = fb[1];
    assign f_type = fb[2];
    assign f_bank = fb[3];
    assign f_value = {fb[4], fb[5], fb[6], fb[7]};
    assign busy_shift = i_home_busy >> f_bank;

    // ************************************************************
    // Frame reception
    // ************************************************************
    assign o_rx_ready = (state == S_RX);
    assign rx_take = i_rx_valid && o_rx_ready;
    // Frames for another address or with a bad sum are dropped without reply
    assign frame_ok = (rx_sum == i_rx_data) && (fb[0] == mod_addr);

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_cnt <= 4'h0;
            rx_sum <= 8'h00;
        end else if (rx_take) begin
            if (rx_cnt == `IOHCH_FRAME_LAST) begin
                rx_cnt <= 4'h0;
                rx_sum <= 8'h00;
            end else begin
                rx_cnt <= rx_cnt + 4'h1;
                rx_sum <= rx_sum + i_rx_data;
            end
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < 8; gb = gb + 1) begin : g_fb
            always @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    fb[gb] <= 8'h00;
                end else if (rx_take && rx_cnt == gb) begin
                    fb[gb] <= i_rx_data;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Command decode
    // ************************************************************
    reg [7:0] d_status;
    reg [31:0] d_value;
    reg d_gp_we;
    reg [7:0] d_gp;
    reg d_pu_we;
    reg d_acc_we;
    reg d_start;
    reg d_stop;

    always @* begin
        d_status = `IOHCH_ST_OK;
        d_value = 32'h00000000;
        d_gp_we = 1'b0;
        d_gp = o_gp_out;
        d_pu_we = 1'b0;
        d_acc_we = 1'b0;
        d_start = 1'b0;
        d_stop = 1'b0;
        case (f_instr)
            `IOHCH_CMD_HOME: begin
                if (f_bank >= N_AXIS) begin
                    d_status = `IOHCH_ST_BAD_VALUE;
                end else begin
                    case (f_type)
                        `IOHCH_HOME_START: d_start = 1'b1;
                        `IOHCH_HOME_STOP: d_stop = 1'b1;
                        `IOHCH_HOME_QUERY: d_value = {31'h0, busy_shift[0]};
                        default: d_status = `IOHCH_ST_BAD_TYPE;
                    endcase
                end
            end
            `IOHCH_CMD_SET: begin
                if (f_bank == `IOHCH_BANK_OUT && f_type < 8'h08) begin
                    if (f_value > 32'h00000001) begin
                        d_status = `IOHCH_ST_BAD_VALUE;
                    end else begin
                        d_gp_we = 1'b1;
                        d_gp[f_type[2:0]] = f_value[0];
                    end
                end else if (f_bank == `IOHCH_BANK_OUT && f_type == `IOHCH_PORT_ALL) begin
                    if (f_value == `IOHCH_VAL_FROM_ACC) begin
                        d_gp_we = 1'b1;
                        d_gp = acc[7:0];
                    end else if (f_value > 32'h000000ff) begin
                        d_status = `IOHCH_ST_BAD_VALUE;
                    end else begin
                        d_gp_we = 1'b1;
                        d_gp = f_value[7:0];
                    end
                end else if (f_bank == `IOHCH_BANK_DIN && f_type == 8'h00) begin
                    if (f_value > 32'h00000001) begin
                        d_status = `IOHCH_ST_BAD_VALUE;
                    end else begin
                        d_pu_we = 1'b1;
                    end
                end else begin
                    d_status = `IOHCH_ST_BAD_TYPE;
                end
            end
            `IOHCH_CMD_GET: begin
                case (f_bank)
                    `IOHCH_BANK_DIN: begin
                        if (f_type < 8'h08) begin
                            d_value = {31'h0, i_din[f_type[2:0]]};
                        end else if (f_type == `IOHCH_PORT_ALL) begin
                            d_value = {24'h0, i_din};
                        end else begin
                            d_status = `IOHCH_ST_BAD_TYPE;
                        end
                    end
                    `IOHCH_BANK_ANA: begin
                        case (f_type)
                            `IOHCH_PORT_ADC0: d_value = {20'h0, i_adc_zero};
                            `IOHCH_PORT_ADC4: d_value = {20'h0, i_adc_four};
                            `IOHCH_PORT_SUPPLY: d_value = {16'h0, i_supply_dv};
                            `IOHCH_PORT_TEMP0: d_value = {{16{i_temp_a[15]}}, i_temp_a};
                            `IOHCH_PORT_TEMP1: d_value = {{16{i_temp_b[15]}}, i_temp_b};
                            `IOHCH_PORT_TEMP2: d_value = {{16{i_temp_c[15]}}, i_temp_c};
                            default: d_status = `IOHCH_ST_BAD_TYPE;
                        endcase
                    end
                    `IOHCH_BANK_OUT: begin
                        if (f_type < 8'h08) begin
                            d_value = {31'h0, o_gp_out[f_type[2:0]]};
                        end else begin
                            d_status = `IOHCH_ST_BAD_TYPE;
                        end
                    end
                    default: d_status = `IOHCH_ST_BAD_TYPE;
                endcase
                // Direct mode leaves the accumulator alone
                d_acc_we = standalone && (d_status == `IOHCH_ST_OK);
            end
            default: d_status = `IOHCH_ST_BAD_CMD;
        endcase
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always @* begin
        next_state = state;
        case (state)
            S_RX: begin
                if (rx_take && rx_cnt == `IOHCH_FRAME_LAST && frame_ok) begin
                    next_state = S_EXEC;
                end
            end
            S_EXEC: next_state = standalone ? S_RX : S_SEND;
            S_SEND: begin
                if (!o_tx_valid) begin
                    next_state = S_RX;
                end
            end
            default: next_state = S_RX;
        endcase
    end

    // Standalone mode runs the command but sends no reply
    assign tx_start = (state == S_EXEC) && !standalone;

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= S_RX;
            o_gp_out <= `IOHCH_RST_GPOUT;
            o_stop_pullup_en <= `IOHCH_RST_PULLUP;
            last_status <= 8'h00;
            exec_cnt <= 16'h0000;
            drop_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            if (state == S_EXEC) begin
                last_status <= d_status;
                exec_cnt <= exec_cnt + 16'h0001;
                if (d_gp_we) begin
                    o_gp_out <= d_gp;
                end
                if (d_pu_we) begin
                    o_stop_pullup_en <= f_value[0];
                end
            end
            if (rx_take && rx_cnt == `IOHCH_FRAME_LAST && !frame_ok) begin
                drop_cnt <= drop_cnt + 16'h0001;
            end
        end
    end

    genvar ga;
    generate
        for (ga = 0; ga < N_AXIS; ga = ga + 1) begin : g_axis
            always @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_home_start[ga] <= 1'b0;
                    o_home_stop[ga] <= 1'b0;
                end else begin
                    o_home_start[ga] <= (state == S_EXEC) && d_start && (f_bank == ga);
                    o_home_stop[ga] <= (state == S_EXEC) && d_stop && (f_bank == ga);
                end
            end
        end
    endgenerate

    iohch_reply_tx u_reply (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_start(tx_start),
        .i_host_addr(host_addr),
        .i_mod_addr(mod_addr),
        .i_status(d_status),
        .i_instr(f_instr),
        .i_value(d_value),
        .o_tx_data(o_tx_data),
        .o_tx_valid(o_tx_valid),
        .i_tx_ready(i_tx_ready)
    );

    // ************************************************************
    // Avalon-MM slave, one wait state on every access
    // ************************************************************
    assign bus_req = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = bus_req && !bus_ack;
    assign bus_wr = i_avs_write && bus_ack;

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_ack <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            bus_ack <= bus_req && !bus_ack;
            if (i_avs_read && !bus_ack) begin
                case (i_avs_address)
                    `IOHCH_OFS_CTRL: o_avs_readdata <= {8'h00, host_addr, mod_addr, 7'h00, standalone};
                    `IOHCH_OFS_ACC: o_avs_readdata <= acc;
                    `IOHCH_OFS_STAT: o_avs_readdata <= {8'h00, last_status, 6'h00,
                        (state != S_RX), o_stop_pullup_en, o_gp_out};
                    `IOHCH_OFS_CNT: o_avs_readdata <= {drop_cnt, exec_cnt};
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            standalone <= 1'b0;
            mod_addr <= `IOHCH_RST_MOD_ADDR;
            host_addr <= `IOHCH_RST_HOST_ADDR;
        end else if (bus_wr && i_avs_address == `IOHCH_OFS_CTRL) begin
            if (i_avs_byteenable[0]) begin
                standalone <= i_avs_writedata[`IOHCH_CTRL_STANDALONE];
            end
            if (i_avs_byteenable[1]) begin
                mod_addr <= i_avs_writedata[`IOHCH_CTRL_MOD_LSB +: 8];
            end
            if (i_avs_byteenable[2]) begin
                host_addr <= i_avs_writedata[`IOHCH_CTRL_HOST_LSB +: 8];
            end
        end
    end

    // A command's accumulator load wins over a software write in the same cycle
    genvar gl;
    generate
        for (gl = 0; gl < 4; gl = gl + 1) begin : g_acc
            always @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    acc[gl*8 +: 8] <= 8'h00;
                end else if (state == S_EXEC && d_acc_we) begin
                    acc[gl*8 +: 8] <= d_value[gl*8 +: 8];
                end else if (bus_wr && i_avs_address == `IOHCH_OFS_ACC && i_avs_byteenable[gl]) begin
                    acc[gl*8 +: 8] <= i_avs_writedata[gl*8 +: 8];
                end
            end
        end
    endgenerate

endmodule

// >>> iohch_top_monitor.sv
// Port checker for the io and homing command handler
`timescale 1ns/1ns
module iohch_monitor #(
    parameter N_AXIS = 3
) (
    input wire i_clk_sys, // System clock
    input wire i_rst_b, // Reset, active low
    input wire i_avs_read, // Avalon read
    input wire i_avs_write, // Avalon write
    input wire o_avs_waitrequest, // Avalon stall
    input wire o_rx_ready, // Command byte accepted
    input wire [7:0] o_tx_data, // Reply byte
    input wire o_tx_valid, // Reply byte valid
    input wire i_tx_ready, // Reply byte taken
    input wire [N_AXIS-1:0] o_home_start, // Homing start pulses
    input wire [N_AXIS-1:0] o_home_stop, // Homing stop pulses
    input wire [7:0] o_gp_out, // General outputs
    input wire o_stop_pullup_en // Stop pull-ups
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // ************************************************************
    // Assertions
    // ************************************************************
    pullup_reset_a: assert property (disable iff (1'b0)
        !i_rst_b |-> o_stop_pullup_en && o_gp_out == 8'h00) else $error("reset state wrong");
    start_onehot_a: assert property (o_home_start != 0 |->
        $onehot(o_home_start) ##1 o_home_start == 0) else $error("start pulse wrong");
    stop_alone_a: assert property (o_home_stop != 0 |->
        o_home_start == 0 ##1 o_home_stop == 0) else $error("stop pulse wrong");
    home_after_frame_a: assert property ((o_home_start | o_home_stop) != 0 |->
        !$past(o_rx_ready)) else $error("homing pulse outside command");
    gp_by_command_a: assert property (!$stable(o_gp_out) |-> !$past(o_rx_ready))
        else $error("outputs changed outside command");
    pullup_by_command_a: assert property (!$stable(o_stop_pullup_en) |->
        !$past(o_rx_ready)) else $error("pull-ups changed outside command");
    reply_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data)) else $error("reply byte dropped");
    reply_blocks_rx_a: assert property (o_tx_valid |-> !o_rx_ready)
        else $error("command taken during reply");
    one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("bus wait too long");
    cover property (o_home_start != 0);
    cover property (o_tx_valid && i_tx_ready);
    cover property ($fell(o_stop_pullup_en));
endmodule
bind iohch_top iohch_monitor #(.N_AXIS(N_AXIS)) u_mon (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest), .o_rx_ready(o_rx_ready), .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_home_start(o_home_start),
    .o_home_stop(o_home_stop), .o_gp_out(o_gp_out), .o_stop_pullup_en(o_stop_pullup_en));

// >>> iohch_host.sv
// Host model: sends command frames and collects reply frames
`timescale 1ns/1ns
module iohch_host (
    input wire i_clk_sys, // System clock
    output logic [7:0] o_rx_data, // Command byte
    output logic o_rx_valid, // Command byte valid
    input wire i_rx_ready, // Handler takes byte
    input wire [7:0] i_tx_data, // Reply byte
    input wire i_tx_valid, // Reply byte valid
    output logic o_tx_ready // Host takes reply byte
);
    logic slow;
    initial begin
        slow = 1'b0;
        o_rx_data = 8'h00;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b1;
    end
    // A slow host stalls every other cycle to test reply holding
    always @(posedge i_clk_sys) o_tx_ready <= !slow || !o_tx_ready;
    task send(input [7:0] a, ins, t, bk, input [31:0] v, input bad);
        logic [71:0] f;
        f[71:8] = {a, ins, t, bk, v};
        f[7:0] = a + ins + t + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad;
        for (int k = 8; k >= 0; k--) begin
            o_rx_data <= f[k*8 +: 8];
            o_rx_valid <= 1'b1;
            do @(posedge i_clk_sys); while (i_rx_ready !== 1'b1);
        end
        o_rx_valid <= 1'b0;
        // Released line shows a changed value, not the stale byte
        o_rx_data <= ~f[7:0];
    endtask
    task get_reply(output logic [71:0] f);
        for (int k = 0; k < 9; k++) begin
            do @(posedge i_clk_sys); while (!(i_tx_valid === 1'b1 && o_tx_ready === 1'b1));
            f = {f[63:0], i_tx_data};
        end
    endtask
endmodule

// >>> iohch_top_bench.sv
// Testbench for the io and homing command handler
`timescale 1ns/1ns
module iohch_top_bench;
    // Reset starts high and falls by NBA at time 0, so the async reset branch sees the edge
    logic clk, rst_b = 1'b1, rd, wr;
    logic [4:0] adr;
    logic [31:0] wdat, d;
    logic [2:0] busy, hs_seen, hp_seen;
    logic [7:0] din;
    logic [11:0] adc0, adc4;
    logic [15:0] sup, ta, tb, tc;
    wire [31:0] rdat;
    wire wait_s, rxr, rxv, txv, txr, pu;
    wire [7:0] rxd, txd, gp;
    wire [2:0] hs, hp;
    int fails = 0, comparisons = 0, cycles = 0;
    iohch_top #(.N_AXIS(3)) dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf), .i_avs_writedata(wdat),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_s), .i_rx_data(rxd), .i_rx_valid(rxv),
        .o_rx_ready(rxr), .o_tx_data(txd), .o_tx_valid(txv), .i_tx_ready(txr),
        .o_home_start(hs), .o_home_stop(hp), .i_home_busy(busy), .o_gp_out(gp),
        .o_stop_pullup_en(pu), .i_din(din), .i_adc_zero(adc0), .i_adc_four(adc4),
        .i_supply_dv(sup), .i_temp_a(ta), .i_temp_b(tb), .i_temp_c(tc));
    iohch_host host (.i_clk_sys(clk), .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rxr),
        .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr));
    // ************************************************************
    // Tasks
    // ************************************************************
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task avs(input logic w, input [4:0] a, input [31:0] v, output logic [31:0] q);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= v;
        do @(posedge clk); while (wait_s !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task cmd(input [7:0] ins, t, bk, input [31:0] v, input [7:0] st, input [31:0] ev, input cv);
        logic [71:0] r;
        logic [7:0] s;
        host.send(8'h01, ins, t, bk, v, 1'b0);
        host.get_reply(r);
        s = 8'h00;
        for (int k = 1; k < 9; k++) s = s + r[k*8 +: 8];
        chk("reply head", {8'h02, 8'h01, st, ins}, r[71:40]);
        chk("reply sum", {24'h0, s}, {24'h0, r[7:0]});
        if (cv)
            chk("reply value", ev, r[39:8]);
    endtask
    always @(posedge clk) begin
        if (hs != 3'b000) hs_seen <= hs;
        if (hp != 3'b000) hp_seen <= hp;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test;
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_b <= 1'b0; rd = 1'b0; wr = 1'b0; adr = 5'h00; wdat = 32'h0; busy = 3'b000;
        hs_seen = 3'b000; hp_seen = 3'b000; din = 8'ha5; adc0 = 12'hfff; adc4 = 12'h123;
        sup = 16'd240; ta = 16'd25; tb = 16'hfff6; tc = 16'h0000;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        avs(1'b0, 5'h00, 32'h0, d); chk("ctrl", 32'h00020100, d);
        avs(1'b0, 5'h08, 32'h0, d); chk("stat", 32'h00000100, d);
        avs(1'b0, 5'h10, 32'h0, d); chk("unmapped", 32'h0, d);
        cmd(8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 32'h0, 1'b1);
        cmd(8'h0d, 8'h00, 8'h01, 32'h0, 8'h64, 32'h0, 1'b0);
        chk("start axis", 32'h2, {29'h0, hs_seen});
        busy <= 3'b100;
        cmd(8'h0d, 8'h02, 8'h02, 32'h0, 8'h64, 32'h1, 1'b1);
        cmd(8'h0d, 8'h01, 8'h02, 32'h0, 8'h64, 32'h0, 1'b0);
        chk("stop axis", 32'h4, {29'h0, hp_seen});
        cmd(8'h0d, 8'h00, 8'h03, 32'h0, 8'h04, 32'h0, 1'b0);
        cmd(8'h0d, 8'h03, 8'h00, 32'h0, 8'h03, 32'h0, 1'b0);
        cmd(8'h0c, 8'h2a, 8'h02, 32'h0, 8'h02, 32'h0, 1'b0);
        cmd(8'h0f, 8'h05, 8'h01, 32'h0, 8'h03, 32'h0, 1'b0);
        for (int p = 0; p < 8; p++) cmd(8'h0e, p[7:0], 8'h02, {31'h0, p[0]}, 8'h64, 0, 0);
        chk("outputs", 32'haa, {24'h0, gp});
        for (int p = 0; p < 8; p++) cmd(8'h0f, p[7:0], 8'h02, 0, 8'h64, {31'h0, p[0]}, 1);
        host.slow <= 1'b1;
        cmd(8'h0e, 8'hff, 8'h02, 32'h5a, 8'h64, 32'h0, 1'b0);
        chk("outputs all", 32'h5a, {24'h0, gp});
        cmd(8'h0e, 8'h00, 8'h02, 32'h2, 8'h04, 32'h0, 1'b0);
        chk("outputs kept", 32'h5a, {24'h0, gp});
        cmd(8'h0e, 8'h00, 8'h00, 32'h0, 8'h64, 32'h0, 1'b0);
        chk("pull-ups off", 32'h0, {31'h0, pu});
        cmd(8'h0e, 8'h00, 8'h00, 32'h1, 8'h64, 32'h0, 1'b0);
        chk("pull-ups on", 32'h1, {31'h0, pu});
        host.slow <= 1'b0;
        avs(1'b1, 5'h04, 32'h12345678, d);
        for (int p = 0; p < 8; p++) cmd(8'h0f, p[7:0], 8'h00, 0, 8'h64, {31'h0, din[p]}, 1);
        cmd(8'h0f, 8'hff, 8'h00, 32'h0, 8'h64, 32'ha5, 1'b1);
        cmd(8'h0f, 8'h00, 8'h01, 32'h0, 8'h64, 32'hfff, 1'b1);
        cmd(8'h0f, 8'h04, 8'h01, 32'h0, 8'h64, 32'h123, 1'b1);
        cmd(8'h0f, 8'h08, 8'h01, 32'h0, 8'h64, 32'd240, 1'b1);
        cmd(8'h0f, 8'h09, 8'h01, 32'h0, 8'h64, 32'd25, 1'b1);
        cmd(8'h0f, 8'h0a, 8'h01, 32'h0, 8'h64, 32'hfffffff6, 1'b1);
        cmd(8'h0f, 8'h0b, 8'h01, 32'h0, 8'h64, 32'h0, 1'b1);
        avs(1'b0, 5'h04, 32'h0, d); chk("acc direct", 32'h12345678, d);
        avs(1'b1, 5'h00, 32'h00020101, d);
        host.send(8'h01, 8'h0f, 8'hff, 8'h00, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        avs(1'b0, 5'h04, 32'h0, d); chk("acc standalone", 32'ha5, d);
        host.send(8'h01, 8'h0e, 8'hff, 8'h02, 32'hffffffff, 1'b0);
        repeat (3) @(posedge clk);
        chk("outputs from acc", 32'ha5, {24'h0, gp});
        host.send(8'h01, 8'h0e, 8'hff, 8'h02, 32'h0, 1'b1);
        repeat (3) @(posedge clk);
        avs(1'b0, 5'h0c, 32'h0, d); chk("dropped frames", 32'h1, {16'h0, d[31:16]});
        chk("outputs after bad sum", 32'ha5, {24'h0, gp});
        finish_test;
    end
endmodule
